// [core/spi_master_slave_port.sv]
// serial peripheral port, master or slave, behind an axi4-lite register slave
// Functional notes
// - standard mode uses one holding stage each way
// - enhanced mode uses eight-deep queues each way
// - four framed configurations, role times sync direction; here a slave never drives the sync pin and a master ignores a sync input
// - 4, 3 and 2 pin operation supported
// - master write to data starts transfer
// - bit 15 enables port and pins
// - bit 13 halts port in idle
// - enhanced: bits 10:8 count pending or unread words
// - bit 7 reads shift register empty
// - overflow sets, discards word, software clears
// - bit 5 reads receive queue empty
// - interrupt select codes for transmit events
// - interrupt select codes for receive events
// - standard: tx full set on write, cleared on load
// - enhanced: tx full when queue full
// - standard: rx full on capture, cleared by read
// - enhanced: rx full when queue full
// - bit 5 of first control picks master
// - word size 16 or 8 bits
// - clock polarity sets idle level
// - clock-edge select picks output change edge
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module spi_master_slave_port
  import spi_port_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_cpu_idle,
  input  wire logic [3:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [3:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  input  wire logic        i_sck,
  input  wire logic        i_sdi,
  input  wire logic        i_ss_n,
  output logic             o_sck,
  output logic             o_sck_oe_n,
  output logic             o_sdo,
  output logic             o_sdo_oe_n,
  output logic             o_ss_n,
  output logic             o_ss_oe_n,
  output logic             o_port_irq
);
  // registers
  logic [15:0] stat_r, con1_r, con2_r;
  logic        ovf_r;
  logic [15:0] txq_r [QDEPTH];
  logic [15:0] rxq_r [QDEPTH];
  logic [QAW-1:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
  logic [QAW:0]   tx_cnt_r, rx_cnt_r;
  logic [15:0] sr_r;
  logic        sr_busy_r;
  logic [4:0]  bit_cnt_r;
  logic [7:0]  div_r;
  shift_state_t st_r;
  logic        sck_int_r, sdo_r, sdi_smp_r, fsync_r;
  logic [2:0]  sck_s, ss_s;
  logic [1:0]  sdi_s;
  logic        aw_got_r, w_got_r;
  logic [3:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        irq_r, prev_ev_r;

  // config decode
  wire en      = stat_r[BIT_PORT_ENABLE];
  wire run     = en && !(stat_r[BIT_IDLE_STOP] && i_cpu_idle);
  wire enh     = con2_r[BIT_ENH_EN];
  wire master  = con1_r[BIT_MASTER];
  wire w16     = con1_r[BIT_WORD16];
  wire clock_polarity     = con1_r[BIT_CKP];
  wire cke     = con1_r[BIT_CKE];
  wire frame   = con2_r[BIT_FRAME_EN];
  wire [QAW:0] qlim = enh ? 4'(QDEPTH) : 4'h1;
  wire [4:0]   nbits = w16 ? BITS16 : BITS8;
  wire tx_full = (tx_cnt_r == qlim);
  wire rx_full = (rx_cnt_r == qlim);
  wire rx_empty = (rx_cnt_r == '0);

  // link input synchronisers; stage 0 only feeds stage 1
  always_ff @(posedge i_sys_clk) begin
    sck_s <= {sck_s[1:0], i_sck};
    ss_s  <= {ss_s[1:0], i_ss_n};
    sdi_s <= {sdi_s[0], i_sdi};
  end
  wire ss_use    = con1_r[BIT_SS_EN] || frame;
  wire slv_sel   = !ss_use || (frame ? (ss_s[1] == con2_r[BIT_FSYNC_POL]) : !ss_s[1]);
  wire sck_lvl   = sck_s[1] ^ clock_polarity;                              // active-high view
  wire sck_prev  = sck_s[2] ^ clock_polarity;
  wire slv_lead  = slv_sel && sck_lvl && !sck_prev;
  wire slv_trail = slv_sel && !sck_lvl && sck_prev;

  // axi4-lite write channel
  wire wr_fire  = aw_got_r && w_got_r && !o_bvalid;
  wire wr_stat  = wr_fire && awaddr_r == OFS_STATUS_CONTROL;
  wire wr_buf   = wr_fire && awaddr_r == OFS_DATA_BUFFER;
  wire wr_map   = awaddr_r == OFS_STATUS_CONTROL || awaddr_r == OFS_FIRST_CONTROL ||
                  awaddr_r == OFS_SECOND_CONTROL || awaddr_r == OFS_DATA_BUFFER;
  wire [15:0] wbe = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire rd_fire  = i_arvalid && o_arready;
  wire rd_buf   = rd_fire && i_araddr == OFS_DATA_BUFFER;

  // transfer engine events
  wire tx_push  = wr_buf && !tx_full;
  wire sr_load  = run && !sr_busy_r && tx_cnt_r != '0 && (master || st_r == ST_IDLE);
  wire lead     = master ? (st_r == ST_LEAD && div_r == '0) : slv_lead;
  wire trail    = master ? (st_r == ST_TRAIL && div_r == '0) : slv_trail;
  wire smp_end  = con1_r[BIT_SMP] && master;
  wire shout    = cke ? trail : lead;
  wire mid      = cke ? lead : trail;
  wire samp     = smp_end ? shout : mid;
  // slave with nothing queued arms with zeros; a word written while armed waits for the next frame
  wire slv_arm  = !master && !sr_busy_r && tx_cnt_r == '0 && slv_sel;
  wire last_edge = sr_busy_r && run && bit_cnt_r == 5'h1 && (cke ? trail : trail);
  wire done     = last_edge;
  wire rx_pop   = rd_buf && !rx_empty;
  wire rx_push  = done && (!rx_full || rx_pop);
  wire ovf_ev   = done && rx_full && !rx_pop;

  // shift engine: msb first, in and out together
  // the bit sampled on a shifting edge goes straight in, not one edge late
  wire in_bit = samp ? sdi_s[1] : sdi_smp_r;
  wire [15:0] shifted = {sr_r[14:0], in_bit};
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst || !en) begin
      sr_r <= '0; sr_busy_r <= 1'b0; bit_cnt_r <= '0; st_r <= ST_IDLE;
      div_r <= '0; sck_int_r <= 1'b0; sdo_r <= 1'b0; sdi_smp_r <= 1'b0; fsync_r <= 1'b0;
    end else if (run) begin
      if (sr_load) begin
        sr_r <= w16 ? txq_r[tx_rp_r] : {txq_r[tx_rp_r][7:0], 8'h00};
        sdo_r <= w16 ? txq_r[tx_rp_r][15] : txq_r[tx_rp_r][7];
        sr_busy_r <= 1'b1; bit_cnt_r <= nbits; div_r <= HALF_CNT;
        st_r <= master ? ST_LEAD : ST_IDLE; fsync_r <= frame;
      end else if (slv_arm) begin
        sr_r <= '0; sdo_r <= 1'b0; sr_busy_r <= 1'b1; bit_cnt_r <= nbits; st_r <= ST_IDLE;
      end else if (sr_busy_r) begin
        if (master) begin
          div_r <= (div_r == '0) ? HALF_CNT : div_r - 8'h1;
          if (div_r == '0) begin
            st_r <= (st_r == ST_LEAD) ? ST_TRAIL : ST_LEAD;
            sck_int_r <= (st_r == ST_LEAD);
            fsync_r <= 1'b0;
          end
        end
        if (samp) sdi_smp_r <= sdi_s[1];
        if (trail) begin
          sr_r <= shifted; bit_cnt_r <= bit_cnt_r - 5'h1;
          if (cke) sdo_r <= shifted[15];
          if (bit_cnt_r == 5'h1) begin
            sr_busy_r <= 1'b0; st_r <= ST_IDLE; sck_int_r <= 1'b0;
          end
        end
        if (!cke && lead) sdo_r <= sr_r[15];
      end
    end
  end
  wire [15:0] rx_word = w16 ? {sr_r[14:0], in_bit} : {8'h00, sr_r[6:0], in_bit};

  // queues and flags
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst || !en) begin
      tx_wp_r <= '0; tx_rp_r <= '0; rx_wp_r <= '0; rx_rp_r <= '0;
      tx_cnt_r <= '0; rx_cnt_r <= '0;
    end else begin
      if (tx_push) begin txq_r[tx_wp_r] <= wdata_r[15:0]; tx_wp_r <= tx_wp_r + 3'h1; end
      if (sr_load) tx_rp_r <= tx_rp_r + 3'h1;
      tx_cnt_r <= tx_cnt_r + 4'(tx_push) - 4'(sr_load);
      if (rx_push) begin rxq_r[rx_wp_r] <= rx_word; rx_wp_r <= rx_wp_r + 3'h1; end
      if (rx_pop) rx_rp_r <= rx_rp_r + 3'h1;
      rx_cnt_r <= rx_cnt_r + 4'(rx_push) - 4'(rx_pop);
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) ovf_r <= 1'b0;
    else if (ovf_ev) ovf_r <= 1'b1;                             // set wins over clear
    else if (wr_stat && wbe[BIT_RX_OVF] && !wdata_r[BIT_RX_OVF]) ovf_r <= 1'b0;
  end

  // interrupt condition: enhanced, edge of the selected event; standard, each received word
  wire [2:0] isel = stat_r[BIT_ISEL_LO +: 3];
  logic ev_lvl;
  always_comb begin
    unique case (isel)
      IS_TX_FULL:  ev_lvl = tx_full;
      IS_TX_LAST:  ev_lvl = sr_busy_r && tx_cnt_r == '0;
      IS_TX_DONE:  ev_lvl = !sr_busy_r && tx_cnt_r == '0;
      IS_TX_ONE:   ev_lvl = !tx_full;
      IS_RX_FULL:  ev_lvl = rx_full;
      IS_RX_3Q:    ev_lvl = rx_cnt_r >= Q_THREE_QUARTER;
      IS_RX_AVAIL: ev_lvl = !rx_empty;
      IS_RX_EMPTY: ev_lvl = rx_empty;
    endcase
  end
  always_ff @(posedge i_sys_clk) begin
    prev_ev_r <= i_nrst && en && ev_lvl;
    irq_r <= i_nrst && en && (enh ? (ev_lvl && !prev_ev_r) : rx_push);
  end

  // status view
  wire [15:0] stat_rd = (stat_r & STAT_WR_MASK)
                      | (16'(enh ? (master ? tx_cnt_r[QAW-1:0] : rx_cnt_r[QAW-1:0]) : 3'h0) << BIT_BEC_LO)
                      | (16'(!sr_busy_r) << BIT_SR_EMPTY)
                      | (16'(ovf_r) << BIT_RX_OVF)
                      | (16'(rx_empty) << BIT_RXQ_EMPTY)
                      | (16'(tx_full) << BIT_TX_FULL)
                      | (16'(rx_full) << BIT_RX_FULL);
  wire [15:0] rd_mux = (i_araddr == OFS_STATUS_CONTROL) ? stat_rd :
                       (i_araddr == OFS_FIRST_CONTROL)  ? con1_r :
                       (i_araddr == OFS_SECOND_CONTROL) ? con2_r :
                       (i_araddr == OFS_DATA_BUFFER)    ? rxq_r[rx_rp_r] : 16'h0000;
  wire rd_map = i_araddr == OFS_STATUS_CONTROL || i_araddr == OFS_FIRST_CONTROL ||
                i_araddr == OFS_SECOND_CONTROL || i_araddr == OFS_DATA_BUFFER;

  // bus slave
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      aw_got_r <= 1'b0; w_got_r <= 1'b0; awaddr_r <= '0; wdata_r <= '0; wstrb_r <= '0;
      o_bvalid <= 1'b0; o_bresp <= RESP_OKAY; o_rvalid <= 1'b0; o_rdata <= '0; o_rresp <= RESP_OKAY;
      stat_r <= '0; con1_r <= '0; con2_r <= '0;
    end else begin
      if (i_awvalid && o_awready) begin aw_got_r <= 1'b1; awaddr_r <= i_awaddr; end
      if (i_wvalid && o_wready) begin w_got_r <= 1'b1; wdata_r <= i_wdata; wstrb_r <= i_wstrb; end
      if (wr_fire) begin
        aw_got_r <= 1'b0; w_got_r <= 1'b0; o_bvalid <= 1'b1;
        o_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
        if (wr_stat) stat_r <= (stat_r & ~(wbe & STAT_WR_MASK)) | (wdata_r[15:0] & wbe & STAT_WR_MASK);
        if (awaddr_r == OFS_FIRST_CONTROL)
          con1_r <= (con1_r & ~(wbe & FIRST_CTRL_MASK)) | (wdata_r[15:0] & wbe & FIRST_CTRL_MASK);
        if (awaddr_r == OFS_SECOND_CONTROL)
          con2_r <= (con2_r & ~(wbe & SECOND_CTRL_MASK)) | (wdata_r[15:0] & wbe & SECOND_CTRL_MASK);
      end else if (o_bvalid && i_bready) o_bvalid <= 1'b0;
      if (rd_fire) begin
        o_rvalid <= 1'b1; o_rdata <= {16'h0000, rd_mux}; o_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (o_rvalid && i_rready) o_rvalid <= 1'b0;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    o_awready <= i_nrst && !aw_got_r && !o_awready && !o_bvalid;
    o_wready  <= i_nrst && !w_got_r && !o_wready && !o_bvalid;
    o_arready <= i_nrst && !o_rvalid && !o_arready;
  end

  // pins; enables active low
  always_ff @(posedge i_sys_clk) begin
    o_sck      <= clock_polarity ^ sck_int_r;
    o_sck_oe_n <= !(i_nrst && en && master && !con1_r[BIT_DIS_SCK]);
    o_sdo      <= sdo_r;
    o_sdo_oe_n <= !(i_nrst && en && !con1_r[BIT_DIS_SDO] && (master || slv_sel));
    o_ss_n     <= frame ? !(fsync_r ^ !con2_r[BIT_FSYNC_POL]) : !sr_busy_r;
    o_ss_oe_n  <= !(i_nrst && en && master && ss_use && !(frame && con2_r[BIT_FSYNC_IN]));
    o_port_irq <= irq_r;
  end

  // checks
  ovf_sticky_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    ovf_ev |=> ovf_r) else $error("overflow not flagged");
  tx_full_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (en && !enh && tx_push) |=> stat_rd[BIT_TX_FULL]) else $error("tx full not set");
  sr_empty_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    sr_load |=> !stat_rd[BIT_SR_EMPTY]) else $error("shift register empty after load");
  rxq_empty_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    rx_push |=> !stat_rd[BIT_RXQ_EMPTY]) else $error("rx queue empty after push");
  disabled_pins_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    !en |=> o_sck_oe_n && o_ss_oe_n) else $error("pins driven while disabled");
  word_len_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (sr_load && !w16) |=> bit_cnt_r == BITS8) else $error("byte length wrong");
  std_irq_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (en && !enh && rx_push) |=> o_port_irq == 1'b0 ##1 o_port_irq) else $error("no irq on word");
  idle_halt_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (!run && $stable(en)) |=> $stable(sr_r)) else $error("shifted while halted");
  cov_load_c: cover property (@(posedge i_sys_clk) sr_load);
  cov_done_c: cover property (@(posedge i_sys_clk) done);
  cov_ovf_c:  cover property (@(posedge i_sys_clk) ovf_ev);
endmodule
`default_nettype wire

// [core/spi_port_pkg.sv]
// constants and carrier types for the serial peripheral port
package spi_port_pkg;
  localparam int unsigned AXI_AW = 4;
  localparam logic [AXI_AW-1:0] OFS_STATUS_CONTROL = 4'h0;
  localparam logic [AXI_AW-1:0] OFS_FIRST_CONTROL  = 4'h4;
  localparam logic [AXI_AW-1:0] OFS_SECOND_CONTROL = 4'h8;
  localparam logic [AXI_AW-1:0] OFS_DATA_BUFFER    = 4'hc;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // status_control_reg fields
  localparam int unsigned BIT_PORT_ENABLE = 15;
  localparam int unsigned BIT_IDLE_STOP   = 13;
  localparam int unsigned BIT_BEC_LO      = 8;
  localparam int unsigned BIT_SR_EMPTY    = 7;
  localparam int unsigned BIT_RX_OVF      = 6;
  localparam int unsigned BIT_RXQ_EMPTY   = 5;
  localparam int unsigned BIT_ISEL_LO     = 2;
  localparam int unsigned BIT_TX_FULL     = 1;
  localparam int unsigned BIT_RX_FULL     = 0;
  // first_control_reg fields
  localparam int unsigned BIT_WORD16    = 10;
  localparam int unsigned BIT_SMP       = 9;
  localparam int unsigned BIT_CKE       = 8;
  localparam int unsigned BIT_SS_EN     = 7;
  localparam int unsigned BIT_CKP       = 6;
  localparam int unsigned BIT_MASTER    = 5;
  localparam int unsigned BIT_DIS_SDO   = 11;
  localparam int unsigned BIT_DIS_SCK   = 12;
  localparam logic [15:0] FIRST_CTRL_MASK  = 16'h1fe0;
  // second_control_reg fields
  localparam int unsigned BIT_FRAME_EN  = 15;
  localparam int unsigned BIT_FSYNC_IN  = 14;
  localparam int unsigned BIT_FSYNC_POL = 13;
  localparam int unsigned BIT_ENH_EN    = 0;
  localparam logic [15:0] SECOND_CTRL_MASK = 16'he001;
  localparam logic [15:0] STAT_WR_MASK     = 16'ha01c;
  // queue and timing
  localparam int unsigned QDEPTH = 8;
  localparam int unsigned QAW    = 3;
  localparam logic [QAW:0] Q_THREE_QUARTER = 4'h6;
  localparam real SYS_CLK_MHZ  = 40.0;
  localparam real SCK_HALF_NS  = 100.0;
  localparam int unsigned HALF_CYC = int'(SCK_HALF_NS * SYS_CLK_MHZ / 1000.0);
  localparam logic [7:0] HALF_CNT = 8'(HALF_CYC - 1);
  localparam logic [4:0] BITS8  = 5'h08;
  localparam logic [4:0] BITS16 = 5'h10;
  localparam logic [2:0] IS_TX_FULL = 3'h7, IS_TX_LAST = 3'h6, IS_TX_DONE = 3'h5, IS_TX_ONE = 3'h4;
  localparam logic [2:0] IS_RX_FULL = 3'h3, IS_RX_3Q = 3'h2, IS_RX_AVAIL = 3'h1, IS_RX_EMPTY = 3'h0;

  typedef struct packed {
    logic sck;
    logic sdo;
    logic ss_n;
  } spi_pins_t;

  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_TRAIL} shift_state_t;
endpackage

// [tb/spi_far_slave.sv]
// behavioural serial peripheral that answers the port while it is master
`timescale 1ns/1ps
`default_nettype none
module spi_far_slave (
  input  wire logic        i_nrst,
  input  wire logic        i_sck,
  input  wire logic        i_sdo,
  input  wire logic [4:0]  i_bits,
  output logic             o_sdi,
  output logic [15:0]      o_got,
  output int               o_frames
);
  logic [15:0] word;
  logic [15:0] sh;
  int          cnt;
  initial begin
    o_got = 16'h0;
    o_frames = 0;
    cnt = 0;
    sh = 16'h0;
  end
  // reply changes every frame so a stale read can never pass for fresh data
  assign word  = 16'h5a3c + 16'(o_frames);
  assign o_sdi = word[int'(i_bits) - 1 - cnt];
  always @(posedge i_sck) sh = {sh[14:0], i_sdo};
  // the clock falls from unknown to 0 in reset; that edge must not count
  always @(negedge i_sck) begin
    if (i_nrst === 1'b1) begin
      cnt = cnt + 1;
      if (cnt == int'(i_bits)) begin
        o_got = sh;
        o_frames = o_frames + 1;
        cnt = 0;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/spi_master_slave_port_test.sv]
// self-checking bench for the serial peripheral port
`timescale 1ns/1ps
`default_nettype none
module spi_master_slave_port_test;
  import spi_port_pkg::*;
  `define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; $display("BAD %s exp %h got %h", nm, e, g); end end
  logic clk = 0, nrst = 0, idle = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, mst = 1, ssck = 0, ssdi = 0, sss_n = 1;
  logic [3:0] awa = 4'h0, ara = 4'h0;
  logic [31:0] wd = 32'h0, rdat;
  logic [1:0] rsp;
  logic [4:0] wbits = BITS8;
  logic awr, wr_r, bv, arr, rv, msck, msck_oe_n, msdo, msdo_oe_n, mss, mss_oe_n, irq, psdi;
  logic [1:0] brsp, rrsp;
  logic [31:0] rd_w;
  logic [15:0] got;
  int frames, failures = 0, num_checks = 0, irqs = 0, f0, i0;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (irq === 1'b1) irqs++;
  spi_master_slave_port i_dut (.i_sys_clk(clk), .i_nrst(nrst), .i_cpu_idle(idle), .i_awaddr(awa), .i_awvalid(awv),
    .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hf), .i_wvalid(wv), .o_wready(wr_r), .o_bresp(brsp), .o_bvalid(bv),
    .i_bready(bry), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rd_w), .o_rresp(rrsp), .o_rvalid(rv),
    .i_rready(rry), .i_sck(ssck), .i_sdi(mst ? psdi : ssdi), .i_ss_n(sss_n), .o_sck(msck), .o_sck_oe_n(msck_oe_n),
    .o_sdo(msdo), .o_sdo_oe_n(msdo_oe_n), .o_ss_n(mss), .o_ss_oe_n(mss_oe_n), .o_port_irq(irq));
  spi_far_slave i_far (.i_nrst(nrst), .i_sck(msck), .i_sdo(msdo), .i_bits(wbits), .o_sdi(psdi), .o_got(got),
    .o_frames(frames));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 3000) begin
      failures++;
      $display("BAD wait timed out");
      report_and_stop();
    end
  endtask
  // whole-word writes only, never read-modify-write
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    int n;
    logic ta, tw;
    ta = 0;
    tw = 0;
    awa <= a; awv <= 1; wd <= {16'h0, d}; wv <= 1; bry <= 1;
    for (n = 0; n < 3000; n++) begin
      @(posedge clk);
      if (!ta && awr === 1'b1) begin ta = 1; awv <= 0; end
      if (!tw && wr_r === 1'b1) begin tw = 1; wv <= 0; end
      if (bv === 1'b1) break;
    end
    tmo(n);
    bry <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a);
    int n;
    logic ta;
    ta = 0;
    ara <= a; arv <= 1; rry <= 1;
    for (n = 0; n < 3000; n++) begin
      @(posedge clk);
      if (!ta && arr === 1'b1) begin ta = 1; arv <= 0; end
      if (rv === 1'b1) break;
    end
    tmo(n);
    rdat = rd_w;
    rsp = rrsp;
    rry <= 0;
    @(posedge clk);
  endtask
  task automatic wait_frames(input int t);
    int n;
    for (n = 0; n < 3000 && frames < t; n++) @(posedge clk);
    tmo(n);
    repeat (8) @(posedge clk);
  endtask
  task automatic t_reset;
    rd(OFS_STATUS_CONTROL);
    `CHK("status reset", 32'h00a0, rdat)
    `CHK("pins released", 1'b1, msck_oe_n)
    rd(4'h2);
    `CHK("unmapped resp", RESP_SLVERR, rsp)
    $display("test reset done");
  endtask
  task automatic t_std;
    wr(OFS_FIRST_CONTROL, 16'h0120);
    wr(OFS_STATUS_CONTROL, 16'h8000);
    `CHK("sck driven", 1'b0, msck_oe_n)
    f0 = frames;
    i0 = irqs;
    wr(OFS_DATA_BUFFER, 16'h00a5);
    wait_frames(f0 + 1);
    `CHK("sent byte", 8'ha5, got[7:0])
    `CHK("std irq", i0 + 1, irqs)
    rd(OFS_STATUS_CONTROL);
    `CHK("rx full", 2'b01, rdat[1:0])
    rd(OFS_DATA_BUFFER);
    `CHK("rx byte", {24'h0, 8'(16'h5a3c + 16'(f0))}, rdat)
    rd(OFS_STATUS_CONTROL);
    `CHK("rx full clear", 1'b0, rdat[BIT_RX_FULL])
    $display("test standard done");
  endtask
  task automatic t_ovf;
    f0 = frames;
    wr(OFS_DATA_BUFFER, 16'h0011);
    wait_frames(f0 + 1);
    wr(OFS_DATA_BUFFER, 16'h0022);
    wait_frames(f0 + 2);
    rd(OFS_STATUS_CONTROL);
    `CHK("overflow", 1'b1, rdat[BIT_RX_OVF])
    rd(OFS_DATA_BUFFER);
    `CHK("first kept", {24'h0, 8'(16'h5a3c + 16'(f0))}, rdat)
    wr(OFS_STATUS_CONTROL, 16'h8000);
    rd(OFS_STATUS_CONTROL);
    `CHK("overflow clear", 1'b0, rdat[BIT_RX_OVF])
    $display("test overflow done");
  endtask
  task automatic t_idle;
    wr(OFS_STATUS_CONTROL, 16'ha000);
    idle <= 1;
    f0 = frames;
    wr(OFS_DATA_BUFFER, 16'h0033);
    repeat (300) @(posedge clk);
    `CHK("halted in idle", f0, frames)
    idle <= 0;
    wait_frames(f0 + 1);
    `CHK("resumed", 8'h33, got[7:0])
    rd(OFS_DATA_BUFFER);
    $display("test idle done");
  endtask
  task automatic t_enh;
    wr(OFS_STATUS_CONTROL, 16'h0000);
    wr(OFS_FIRST_CONTROL, 16'h0520);
    wbits <= BITS16;
    wr(OFS_SECOND_CONTROL, 16'h0001);
    wr(OFS_STATUS_CONTROL, 16'h8004);
    f0 = frames;
    i0 = irqs;
    for (int k = 0; k < 9; k++) wr(OFS_DATA_BUFFER, 16'h1000 + 16'(k));
    rd(OFS_STATUS_CONTROL);
    `CHK("tx queue full", 1'b1, rdat[BIT_TX_FULL])
    wr(OFS_DATA_BUFFER, 16'hdead);
    wait_frames(f0 + 9);
    repeat (300) @(posedge clk);
    `CHK("full write dropped", f0 + 9, frames)
    `CHK("last sent", 16'h1008, got)
    `CHK("avail irq", 1'b1, 1'(irqs > i0))
    rd(OFS_STATUS_CONTROL);
    `CHK("enh flags", 4'b1101, {rdat[BIT_SR_EMPTY], rdat[BIT_RX_OVF], rdat[BIT_RXQ_EMPTY], rdat[BIT_RX_FULL]})
    for (int k = 0; k < 8; k++) begin
      rd(OFS_DATA_BUFFER);
      `CHK("rx queue word", {16'h0, 16'h5a3c + 16'(f0 + k)}, rdat)
    end
    rd(OFS_STATUS_CONTROL);
    `CHK("rx drained", 2'b10, {rdat[BIT_RXQ_EMPTY], rdat[BIT_RX_FULL]})
    $display("test enhanced done");
  endtask
  task automatic t_slave;
    logic [7:0] b;
    b = 8'h96;
    wr(OFS_STATUS_CONTROL, 16'h0000); // disabling flushes the data buffer
    wr(OFS_SECOND_CONTROL, 16'h0000);
    wr(OFS_FIRST_CONTROL, 16'h0180); // sample phase clear, select enabled with clock edge
    wr(OFS_STATUS_CONTROL, 16'h8000);
    `CHK("slave sck input", 1'b1, msck_oe_n)
    mst <= 0;
    sss_n <= 0;
    for (int k = 7; k >= 0; k--) begin
      ssdi <= b[k];
      repeat (4) @(posedge clk);
      ssck <= 1;
      repeat (4) @(posedge clk);
      ssck <= 0;
    end
    repeat (8) @(posedge clk);
    sss_n <= 1;
    rd(OFS_STATUS_CONTROL);
    `CHK("slave rx full", 1'b1, rdat[BIT_RX_FULL])
    rd(OFS_DATA_BUFFER);
    `CHK("slave byte", 32'h96, rdat)
    $display("test slave done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    t_reset();
    t_std();
    t_ovf();
    t_idle();
    t_enh();
    t_slave();
    report_and_stop();
  end
endmodule
`default_nettype wire
